// ---- src/keypress_switch_defs.vh ----
`ifndef KEYPRESS_SWITCH_DEFS_VH
`define KEYPRESS_SWITCH_DEFS_VH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define ADDR_KEY_SET_A      8'h05
`define ADDR_KEY_SET_B      8'h06
`define ADDR_FET_SW_CTRL    8'h07
`define ADDR_MATRIX_SW_CTRL 8'h08

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define KEY_DETECT_EN_BIT   2
`define RAW_MODE_EN_BIT     1
`define ADC_TRIGGER_BIT     0
`define BIAS_SEL_HI         5
`define BIAS_SEL_LO         3
`define REL_DEB_BIT         2
`define PRESS_DEB_HI        1
`define PRESS_DEB_LO        0

// ----------------------------------------------------------------
// Writable masks and reset values
// ----------------------------------------------------------------
`define MASK_KEY_SET_A      8'h07
`define MASK_KEY_SET_B      8'h3F
`define MASK_FET_SW         8'h3F
`define MASK_MATRIX_SW      8'h0F
`define RST_KEY_SET_A       8'h00
`define RST_KEY_SET_B       8'h0E
`define RST_FET_SW          8'h00
`define RST_MATRIX_SW       8'h00

// ----------------------------------------------------------------
// Timing: debounce times in microseconds, clock at 100 MHz
// ----------------------------------------------------------------
`define CLK_MHZ             100
`define DEB_2MS_US          2000
`define DEB_20MS_US         20000
`define DEB_40MS_US         40000
`define DEB_80MS_US         80000
`define DEB_120MS_US        120000
`define US_TO_CYC(us)       ((us) * `CLK_MHZ)
// Same times as 24-bit timer loads, so no bits are cut at the timer port
`define DEB_2MS_CYC         24'h030D40
`define DEB_20MS_CYC        24'h1E8480
`define DEB_40MS_CYC        24'h3D0900
`define DEB_80MS_CYC        24'h7A1200
`define DEB_120MS_CYC       24'hB71B00

`endif

// ---- src/debounce_timer.v ----
`timescale 1ns/100ps
// Counts down a loaded cycle count and pulses done at expiry
module debounce_timer
(
	input  wire        clk,
	input  wire        rst_b,
	input  wire        start,
	input  wire [23:0] load_cycles,
	output reg         done
);
	reg [23:0] cnt_q;
	reg        run_q;

	// ----------------------------------------------------------------
	// Down counter
	// ----------------------------------------------------------------
	// Restart on start; a start mid-run reloads the count
	always @(posedge clk)
	begin
		if (!rst_b)
		begin
			cnt_q <= 24'h000000;
			run_q <= 1'b0;
			done  <= 1'b0;
		end
		else
		begin
			done <= 1'b0;
			if (start)
			begin
				cnt_q <= load_cycles;
				run_q <= 1'b1;
			end
			else if (run_q)
			begin
				if (cnt_q <= 24'h000001)
				begin
					run_q <= 1'b0;
					done  <= 1'b1;
				end
				else
					cnt_q <= cnt_q - 24'h000001;
			end
		end
	end
endmodule

// ---- src/sync_two_ff.v ----
`timescale 1ns/100ps
// Two flip-flop synchroniser for a pin level
module sync_two_ff
(
	input  wire clk,
	input  wire rst_b,
	input  wire d,
	output reg  q
);
	reg meta_q;

	// ----------------------------------------------------------------
	// Synchroniser chain
	// ----------------------------------------------------------------
	// First stage feeds only the second stage
	always @(posedge clk)
	begin
		if (!rst_b)
		begin
			meta_q <= 1'b0;
			q      <= 1'b0;
		end
		else
		begin
			meta_q <= d;
			q      <= meta_q;
		end
	end
endmodule

// ---- src/keypress_and_switch_control_regs.v ----
`timescale 1ns/100ps
`include "keypress_switch_defs.vh"
module keypress_and_switch_control_regs
(
	input  wire       CLK,
	input  wire       RST_B,
	input  wire       REG_WR,
	input  wire       REG_RD,
	input  wire [7:0] REG_ADDR,
	input  wire [7:0] REG_WDATA,
	output reg  [7:0] REG_RDATA,
	input  wire       MANUAL_SW_EN,
	input  wire       ACCESSORY_REMOVED,
	input  wire [5:0] AUTO_FET_SW,
	input  wire [3:0] AUTO_MATRIX_SW,
	input  wire       KEY_LEVEL,
	input  wire       ADC_DONE,
	input  wire [6:0] ADC_RESULT,
	output reg        ADC_START,
	output reg        ADC_COMPLETE_EVENT,
	output reg  [7:0] ADC_OUTPUT,
	output reg        KEY_PRESS_EVENT,
	output reg        KEY_RELEASE_EVENT,
	output reg        KEY_DETECT_ACTIVE,
	output reg        RAW_MODE_ACTIVE,
	output reg  [2:0] BIAS_VOLTAGE_SELECT,
	output reg        SLEEVE_GROUND_SWITCH,
	output reg        RING_TWO_GROUND_SWITCH,
	output reg        SLEEVE_DEPLETION_SWITCH,
	output reg        RING_TWO_DEPLETION_SWITCH,
	output reg        SIGNAL_SWITCH_2,
	output reg        SIGNAL_SWITCH_1,
	output reg        MATRIX_PATH_PS_SWITCH,
	output reg        MATRIX_PATH_PR_SWITCH,
	output reg        MATRIX_PATH_GS_SWITCH,
	output reg        MATRIX_PATH_GR_SWITCH
);

	// ----------------------------------------------------------------
	// Key sequencer states
	// ----------------------------------------------------------------
	localparam [1:0] ST_IDLE     = 2'b00;
	localparam [1:0] ST_PRESS    = 2'b01;
	localparam [1:0] ST_HELD     = 2'b10;
	localparam [1:0] ST_RELEASE  = 2'b11;

	reg  [7:0]  key_set_a_q;
	reg  [7:0]  key_set_b_q;
	reg  [7:0]  fet_sw_q;
	reg  [7:0]  matrix_sw_q;
	reg  [7:0]  key_set_a_d;
	reg         conv_busy_q;
	reg  [1:0]  state_q;
	reg  [1:0]  state_d;
	reg         tmr_start;
	reg  [23:0] tmr_load;
	wire        tmr_done;
	wire        key_sync;
	wire        manual_sync;
	wire        removed_sync;
	wire        detect_en;
	wire        raw_en;
	wire        wr_a;

	// Press debounce cycles for a code; nominal values, inside tolerance
	function [23:0] press_cycles;
		input [1:0] code;
		begin
			case (code)
				2'b00:   press_cycles = `DEB_2MS_CYC;
				2'b01:   press_cycles = `DEB_40MS_CYC;
				2'b10:   press_cycles = `DEB_80MS_CYC;
				default: press_cycles = `DEB_120MS_CYC;
			endcase
		end
	endfunction

	// Register map read decode with reserved bits forced to zero
	function [7:0] read_mux;
		input [7:0] addr;
		input [7:0] a;
		input [7:0] b;
		input [7:0] f;
		input [7:0] m;
		begin
			case (addr)
				`ADDR_KEY_SET_A:      read_mux = a & `MASK_KEY_SET_A;
				`ADDR_KEY_SET_B:      read_mux = b & `MASK_KEY_SET_B;
				`ADDR_FET_SW_CTRL:    read_mux = f & `MASK_FET_SW;
				`ADDR_MATRIX_SW_CTRL: read_mux = m & `MASK_MATRIX_SW;
				default:              read_mux = 8'h00;
			endcase
		end
	endfunction

	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------
	sync_two_ff u_sync_key
	(
		.clk   (CLK),
		.rst_b (RST_B),
		.d     (KEY_LEVEL),
		.q     (key_sync)
	);

	sync_two_ff u_sync_manual
	(
		.clk   (CLK),
		.rst_b (RST_B),
		.d     (MANUAL_SW_EN),
		.q     (manual_sync)
	);

	sync_two_ff u_sync_removed
	(
		.clk   (CLK),
		.rst_b (RST_B),
		.d     (ACCESSORY_REMOVED),
		.q     (removed_sync)
	);

	assign detect_en = key_set_a_q[`KEY_DETECT_EN_BIT];
	assign raw_en    = key_set_a_q[`RAW_MODE_EN_BIT];
	assign wr_a      = REG_WR && (REG_ADDR == `ADDR_KEY_SET_A);

	// ----------------------------------------------------------------
	// First key settings register next value
	// ----------------------------------------------------------------
	// Removal wins over a host write; a fresh trigger wins over the done clear
	always @*
	begin
		key_set_a_d = key_set_a_q;
		if (conv_busy_q && ADC_DONE)
			key_set_a_d[`ADC_TRIGGER_BIT] = 1'b0;
		if (wr_a)
		begin
			key_set_a_d = REG_WDATA & `MASK_KEY_SET_A;
			// Trigger only sticks when both enables end up set
			if (!(REG_WDATA[`KEY_DETECT_EN_BIT] && REG_WDATA[`RAW_MODE_EN_BIT]))
				key_set_a_d[`ADC_TRIGGER_BIT] = 1'b0;
			if (!REG_WDATA[`KEY_DETECT_EN_BIT])
				key_set_a_d[`RAW_MODE_EN_BIT] = 1'b0;
			// A running conversion keeps its trigger bit until done
			if (conv_busy_q && !ADC_DONE)
				key_set_a_d[`ADC_TRIGGER_BIT] = 1'b1;
		end
		if (removed_sync)
		begin
			key_set_a_d[`KEY_DETECT_EN_BIT] = 1'b0;
			key_set_a_d[`RAW_MODE_EN_BIT]   = 1'b0;
			if (!conv_busy_q)
				key_set_a_d[`ADC_TRIGGER_BIT] = 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Register file
	// ----------------------------------------------------------------
	always @(posedge CLK)
	begin
		if (!RST_B)
		begin
			key_set_a_q <= `RST_KEY_SET_A;
			key_set_b_q <= `RST_KEY_SET_B;
			fet_sw_q    <= `RST_FET_SW;
			matrix_sw_q <= `RST_MATRIX_SW;
			REG_RDATA   <= 8'h00;
		end
		else
		begin
			key_set_a_q <= key_set_a_d;
			if (REG_WR && REG_ADDR == `ADDR_KEY_SET_B)
				key_set_b_q <= REG_WDATA & `MASK_KEY_SET_B;
			if (REG_WR && REG_ADDR == `ADDR_FET_SW_CTRL)
				fet_sw_q <= REG_WDATA & `MASK_FET_SW;
			if (REG_WR && REG_ADDR == `ADDR_MATRIX_SW_CTRL)
				matrix_sw_q <= REG_WDATA & `MASK_MATRIX_SW;
			if (REG_RD)
				REG_RDATA <= read_mux(REG_ADDR, key_set_a_q, key_set_b_q,
					fet_sw_q, matrix_sw_q);
		end
	end

	// ----------------------------------------------------------------
	// Manual ADC conversion
	// ----------------------------------------------------------------
	// Completion event ignores whether the host serviced the last one
	always @(posedge CLK)
	begin
		if (!RST_B)
		begin
			conv_busy_q        <= 1'b0;
			ADC_START          <= 1'b0;
			ADC_COMPLETE_EVENT <= 1'b0;
			ADC_OUTPUT         <= 8'h00;
		end
		else
		begin
			ADC_START          <= 1'b0;
			ADC_COMPLETE_EVENT <= 1'b0;
			if (conv_busy_q && ADC_DONE)
			begin
				conv_busy_q        <= 1'b0;
				ADC_COMPLETE_EVENT <= 1'b1;
				ADC_OUTPUT         <= {ADC_RESULT, 1'b0};
			end
			else if (!conv_busy_q && key_set_a_d[`ADC_TRIGGER_BIT] && !removed_sync)
			begin
				conv_busy_q <= 1'b1;
				ADC_START   <= 1'b1;
			end
			else if (state_q == ST_PRESS && key_sync && tmr_done && raw_en)
				ADC_OUTPUT <= {ADC_RESULT, 1'b0};
		end
	end

	// ----------------------------------------------------------------
	// Key press and release sequencer
	// ----------------------------------------------------------------
	// Raw mode only makes a debounced press latch ADC_RESULT into ADC_OUTPUT; interrupt contents live elsewhere
	always @*
	begin
		state_d   = state_q;
		tmr_start = 1'b0;
		tmr_load  = press_cycles(key_set_b_q[`PRESS_DEB_HI:`PRESS_DEB_LO]);
		case (state_q)
			ST_IDLE:
				if (detect_en && key_sync)
				begin
					state_d   = ST_PRESS;
					tmr_start = 1'b1;
				end
			ST_PRESS:
				if (!key_sync)
					state_d = ST_IDLE;
				else if (tmr_done)
					state_d = ST_HELD;
			ST_HELD:
				if (!key_sync)
				begin
					state_d   = ST_RELEASE;
					tmr_start = 1'b1;
					tmr_load  = key_set_b_q[`REL_DEB_BIT] ? `DEB_20MS_CYC
						: `DEB_2MS_CYC;
				end
			ST_RELEASE:
				if (key_sync)
					state_d = ST_HELD;
				else if (tmr_done)
					state_d = ST_IDLE;
			default:
				state_d = ST_IDLE;
		endcase
		if (!detect_en)
			state_d = ST_IDLE;
	end

	debounce_timer u_debounce
	(
		.clk         (CLK),
		.rst_b       (RST_B),
		.start       (tmr_start),
		.load_cycles (tmr_load),
		.done        (tmr_done)
	);

	// State register and event pulses
	always @(posedge CLK)
	begin
		if (!RST_B)
		begin
			state_q           <= ST_IDLE;
			KEY_PRESS_EVENT   <= 1'b0;
			KEY_RELEASE_EVENT <= 1'b0;
		end
		else
		begin
			state_q           <= state_d;
			KEY_PRESS_EVENT   <= (state_q == ST_PRESS) && key_sync && tmr_done
				&& detect_en;
			KEY_RELEASE_EVENT <= (state_q == ST_RELEASE) && !key_sync && tmr_done
				&& detect_en;
		end
	end

	// ----------------------------------------------------------------
	// Switch drive
	// ----------------------------------------------------------------
	// Switch registers only matter in manual mode; otherwise automatic values pass
	always @(posedge CLK)
	begin
		if (!RST_B)
		begin
			KEY_DETECT_ACTIVE         <= 1'b0;
			RAW_MODE_ACTIVE           <= 1'b0;
			BIAS_VOLTAGE_SELECT       <= 3'h1;
			SLEEVE_GROUND_SWITCH      <= 1'b0;
			RING_TWO_GROUND_SWITCH    <= 1'b0;
			SLEEVE_DEPLETION_SWITCH   <= 1'b0;
			RING_TWO_DEPLETION_SWITCH <= 1'b0;
			SIGNAL_SWITCH_2           <= 1'b0;
			SIGNAL_SWITCH_1           <= 1'b0;
			MATRIX_PATH_PS_SWITCH     <= 1'b0;
			MATRIX_PATH_PR_SWITCH     <= 1'b0;
			MATRIX_PATH_GS_SWITCH     <= 1'b0;
			MATRIX_PATH_GR_SWITCH     <= 1'b0;
		end
		else
		begin
			KEY_DETECT_ACTIVE   <= detect_en;
			RAW_MODE_ACTIVE     <= raw_en;
			BIAS_VOLTAGE_SELECT <= key_set_b_q[`BIAS_SEL_HI:`BIAS_SEL_LO];
			if (manual_sync)
			begin
				SLEEVE_GROUND_SWITCH      <= fet_sw_q[5];
				RING_TWO_GROUND_SWITCH    <= fet_sw_q[4];
				SLEEVE_DEPLETION_SWITCH   <= fet_sw_q[3];
				RING_TWO_DEPLETION_SWITCH <= fet_sw_q[2];
				SIGNAL_SWITCH_2           <= fet_sw_q[1];
				SIGNAL_SWITCH_1           <= fet_sw_q[0];
				MATRIX_PATH_PS_SWITCH     <= matrix_sw_q[3];
				MATRIX_PATH_PR_SWITCH     <= matrix_sw_q[2];
				MATRIX_PATH_GS_SWITCH     <= matrix_sw_q[1];
				MATRIX_PATH_GR_SWITCH     <= matrix_sw_q[0];
			end
			else
			begin
				SLEEVE_GROUND_SWITCH      <= AUTO_FET_SW[5];
				RING_TWO_GROUND_SWITCH    <= AUTO_FET_SW[4];
				SLEEVE_DEPLETION_SWITCH   <= AUTO_FET_SW[3];
				RING_TWO_DEPLETION_SWITCH <= AUTO_FET_SW[2];
				SIGNAL_SWITCH_2           <= AUTO_FET_SW[1];
				SIGNAL_SWITCH_1           <= AUTO_FET_SW[0];
				MATRIX_PATH_PS_SWITCH     <= AUTO_MATRIX_SW[3];
				MATRIX_PATH_PR_SWITCH     <= AUTO_MATRIX_SW[2];
				MATRIX_PATH_GS_SWITCH     <= AUTO_MATRIX_SW[1];
				MATRIX_PATH_GR_SWITCH     <= AUTO_MATRIX_SW[0];
			end
		end
	end
endmodule

// ---- tb/keypress_regs_props.sv ----
`timescale 1ns/100ps
module keypress_regs_props
(
	input wire       CLK,
	input wire       RST_B,
	input wire       MANUAL_SW_EN,
	input wire       ACCESSORY_REMOVED,
	input wire [5:0] AUTO_FET_SW,
	input wire [3:0] AUTO_MATRIX_SW,
	input wire       ADC_DONE,
	input wire [6:0] ADC_RESULT,
	input wire       ADC_START,
	input wire       ADC_COMPLETE_EVENT,
	input wire [7:0] ADC_OUTPUT,
	input wire       KEY_PRESS_EVENT,
	input wire       KEY_RELEASE_EVENT,
	input wire       KEY_DETECT_ACTIVE,
	input wire       RAW_MODE_ACTIVE,
	input wire [2:0] BIAS_VOLTAGE_SELECT,
	input wire       SLEEVE_GROUND_SWITCH,
	input wire       RING_TWO_GROUND_SWITCH,
	input wire       SLEEVE_DEPLETION_SWITCH,
	input wire       RING_TWO_DEPLETION_SWITCH,
	input wire       SIGNAL_SWITCH_2,
	input wire       SIGNAL_SWITCH_1,
	input wire       MATRIX_PATH_PS_SWITCH,
	input wire       MATRIX_PATH_PR_SWITCH,
	input wire       MATRIX_PATH_GS_SWITCH,
	input wire       MATRIX_PATH_GR_SWITCH
);
	reg        busy_q;
	wire [5:0] fet_sw = {SLEEVE_GROUND_SWITCH, RING_TWO_GROUND_SWITCH, SLEEVE_DEPLETION_SWITCH,
		RING_TWO_DEPLETION_SWITCH, SIGNAL_SWITCH_2, SIGNAL_SWITCH_1};
	wire [3:0] mat_sw = {MATRIX_PATH_PS_SWITCH, MATRIX_PATH_PR_SWITCH, MATRIX_PATH_GS_SWITCH,
		MATRIX_PATH_GR_SWITCH};
	// Own view of a running conversion; removal does not abort it
	always @(posedge CLK)
	begin
		if (!RST_B)
			busy_q <= 1'b0;
		else if (ADC_START)
			busy_q <= 1'b1;
		else if (ADC_DONE)
			busy_q <= 1'b0;
	end
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RST_B);
	// ----------------------------------------------------------------
	// Sequences
	// ----------------------------------------------------------------
	sequence s_conv_end;
		busy_q && ADC_DONE;
	endsequence
	// Five cycles covers the pin synchroniser plus output register
	sequence s_auto_settled;
		(!MANUAL_SW_EN && $stable(AUTO_FET_SW) && $stable(AUTO_MATRIX_SW)) [*5];
	endsequence
	// ----------------------------------------------------------------
	// Properties
	// ----------------------------------------------------------------
	a_done_loads_output: assert property (
		s_conv_end |=> ADC_COMPLETE_EVENT && ADC_OUTPUT == {$past(ADC_RESULT), 1'b0})
		else $error("conversion end not reported");
	a_event_has_cause: assert property (
		ADC_COMPLETE_EVENT |-> $past(busy_q) && $past(ADC_DONE))
		else $error("completion without a conversion");
	a_one_at_time: assert property (busy_q |-> !ADC_START)
		else $error("start while busy");
	a_output_lsb_zero: assert property (ADC_OUTPUT[0] == 1'b0)
		else $error("result lsb not zero");
	a_output_holds: assert property (
		!ADC_COMPLETE_EVENT && !$past(RAW_MODE_ACTIVE) |-> $stable(ADC_OUTPUT))
		else $error("result changed unprompted");
	a_raw_needs_detect: assert property (RAW_MODE_ACTIVE |-> KEY_DETECT_ACTIVE)
		else $error("raw mode without detect");
	a_removal_clears: assert property (
		ACCESSORY_REMOVED [*3] |-> ##[1:4] (!KEY_DETECT_ACTIVE && !RAW_MODE_ACTIVE))
		else $error("removal left detect on");
	a_auto_fet: assert property (s_auto_settled |-> fet_sw == AUTO_FET_SW)
		else $error("fet switches not automatic");
	a_auto_matrix: assert property (s_auto_settled |-> mat_sw == AUTO_MATRIX_SW)
		else $error("matrix switches not automatic");
	a_bias_reset: assert property ($rose(RST_B) |-> BIAS_VOLTAGE_SELECT == 3'h1)
		else $error("bias reset code wrong");
	a_event_needs_detect: assert property (
		KEY_PRESS_EVENT || KEY_RELEASE_EVENT |-> KEY_DETECT_ACTIVE)
		else $error("key event with detect off");
endmodule
bind keypress_and_switch_control_regs keypress_regs_props u_props
(
	.CLK(CLK), .RST_B(RST_B), .MANUAL_SW_EN(MANUAL_SW_EN),
	.ACCESSORY_REMOVED(ACCESSORY_REMOVED), .AUTO_FET_SW(AUTO_FET_SW),
	.AUTO_MATRIX_SW(AUTO_MATRIX_SW), .ADC_DONE(ADC_DONE), .ADC_RESULT(ADC_RESULT),
	.ADC_START(ADC_START), .ADC_COMPLETE_EVENT(ADC_COMPLETE_EVENT), .ADC_OUTPUT(ADC_OUTPUT),
	.KEY_PRESS_EVENT(KEY_PRESS_EVENT), .KEY_RELEASE_EVENT(KEY_RELEASE_EVENT),
	.KEY_DETECT_ACTIVE(KEY_DETECT_ACTIVE), .RAW_MODE_ACTIVE(RAW_MODE_ACTIVE),
	.BIAS_VOLTAGE_SELECT(BIAS_VOLTAGE_SELECT), .SLEEVE_GROUND_SWITCH(SLEEVE_GROUND_SWITCH),
	.RING_TWO_GROUND_SWITCH(RING_TWO_GROUND_SWITCH),
	.SLEEVE_DEPLETION_SWITCH(SLEEVE_DEPLETION_SWITCH),
	.RING_TWO_DEPLETION_SWITCH(RING_TWO_DEPLETION_SWITCH), .SIGNAL_SWITCH_2(SIGNAL_SWITCH_2),
	.SIGNAL_SWITCH_1(SIGNAL_SWITCH_1), .MATRIX_PATH_PS_SWITCH(MATRIX_PATH_PS_SWITCH),
	.MATRIX_PATH_PR_SWITCH(MATRIX_PATH_PR_SWITCH), .MATRIX_PATH_GS_SWITCH(MATRIX_PATH_GS_SWITCH),
	.MATRIX_PATH_GR_SWITCH(MATRIX_PATH_GR_SWITCH)
);

// ---- tb/adc_model.sv ----
`timescale 1ns/100ps
module adc_model
(
	input  wire       clk,
	input  wire       rst_b,
	input  wire       start,
	input  wire [7:0] lat,
	input  wire [6:0] value,
	output reg        done,
	output reg  [6:0] result
);
	reg [7:0] cnt_q;
	// Result line is only valid with done; otherwise it toggles
	always @(posedge clk)
	begin
		done <= rst_b && cnt_q == 8'h01;
		result <= (cnt_q == 8'h01) ? value : ~result;
		if (!rst_b)
			cnt_q <= 8'h00;
		else if (start)
			cnt_q <= lat;
		else if (cnt_q != 8'h00)
			cnt_q <= cnt_q - 8'h01;
	end
endmodule

// ---- tb/keypress_and_switch_control_regs_tb_top.sv ----
`timescale 1ns/100ps
module keypress_and_switch_control_regs_tb_top;
	reg        CLK = 1'b0;
	reg        RST_B = 1'b0;
	reg        REG_WR = 1'b0;
	reg        REG_RD = 1'b0;
	reg  [7:0] REG_ADDR = 8'h00;
	reg  [7:0] REG_WDATA = 8'h00;
	reg        MANUAL_SW_EN = 1'b0;
	reg        ACCESSORY_REMOVED = 1'b0;
	reg        KEY_LEVEL = 1'b0;
	reg  [5:0] AUTO_FET_SW = 6'h00;
	reg  [3:0] AUTO_MATRIX_SW = 4'h0;
	reg  [7:0] adc_lat = 8'h14;
	reg  [6:0] adc_val = 7'h00;
	reg  [31:0] d;
	wire [7:0] REG_RDATA;
	wire [7:0] ADC_OUTPUT;
	wire [6:0] ADC_RESULT;
	wire [2:0] BIAS_VOLTAGE_SELECT;
	wire [9:0] sw;
	wire       ADC_DONE, ADC_START, ADC_COMPLETE_EVENT, KEY_DETECT_ACTIVE, RAW_MODE_ACTIVE;
	wire       KEY_PRESS_EVENT, KEY_RELEASE_EVENT;
	integer    errors = 0, check_count = 0, seed = 45683, cycles = 0, starts = 0, i, t;
	integer    reg_a = 0, reg_b = 8'h0E, reg_f = 0, reg_m = 0, presses = 0;

	keypress_and_switch_control_regs dut_u
	(
		.CLK(CLK), .RST_B(RST_B), .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_ADDR(REG_ADDR),
		.REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA), .MANUAL_SW_EN(MANUAL_SW_EN),
		.ACCESSORY_REMOVED(ACCESSORY_REMOVED), .AUTO_FET_SW(AUTO_FET_SW),
		.AUTO_MATRIX_SW(AUTO_MATRIX_SW), .KEY_LEVEL(KEY_LEVEL), .ADC_DONE(ADC_DONE),
		.ADC_RESULT(ADC_RESULT), .ADC_START(ADC_START), .ADC_COMPLETE_EVENT(ADC_COMPLETE_EVENT),
		.ADC_OUTPUT(ADC_OUTPUT), .KEY_PRESS_EVENT(KEY_PRESS_EVENT),
		.KEY_RELEASE_EVENT(KEY_RELEASE_EVENT),
		.KEY_DETECT_ACTIVE(KEY_DETECT_ACTIVE), .RAW_MODE_ACTIVE(RAW_MODE_ACTIVE),
		.BIAS_VOLTAGE_SELECT(BIAS_VOLTAGE_SELECT), .SLEEVE_GROUND_SWITCH(sw[9]),
		.RING_TWO_GROUND_SWITCH(sw[8]), .SLEEVE_DEPLETION_SWITCH(sw[7]),
		.RING_TWO_DEPLETION_SWITCH(sw[6]), .SIGNAL_SWITCH_2(sw[5]), .SIGNAL_SWITCH_1(sw[4]),
		.MATRIX_PATH_PS_SWITCH(sw[3]), .MATRIX_PATH_PR_SWITCH(sw[2]),
		.MATRIX_PATH_GS_SWITCH(sw[1]), .MATRIX_PATH_GR_SWITCH(sw[0])
	);
	adc_model adc_u
	(
		.clk(CLK), .rst_b(RST_B), .start(ADC_START), .lat(adc_lat), .value(adc_val),
		.done(ADC_DONE), .result(ADC_RESULT)
	);
	// ----------------------------------------------------------------
	// Clock, start counter and hang guard
	// ----------------------------------------------------------------
	initial
	begin
		forever #5 CLK = ~CLK;
	end
	always @(posedge CLK)
	begin
		starts = starts + (ADC_START === 1'b1);
		presses = presses + (KEY_PRESS_EVENT === 1'b1) + (KEY_RELEASE_EVENT === 1'b1);
		cycles = cycles + 1;
		if (cycles == 20000)
		begin
			errors = errors + 1;
			summarize;
		end
	end
	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	task check(input [7:0] seen, input [7:0] exp);
		begin
			check_count = check_count + 1;
			if (seen !== exp)
			begin
				errors = errors + 1;
				$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
			end
		end
	endtask
	task tick;
		begin
			@(posedge CLK);
			#1;
		end
	endtask
	// Idle cycle after each strobe keeps one assignment per time step
	task wr(input [7:0] a, input [7:0] v);
		reg [7:0] k;
		begin
			REG_ADDR = a;
			REG_WDATA = v;
			REG_WR = 1'b1;
			tick;
			REG_WR = 1'b0;
			tick;
			k = v & 8'h07;
			k[1] = k[1] & k[2];
			k[0] = k[0] & k[1];
			case (a)
				8'h05: reg_a = k;
				8'h06: reg_b = v & 8'h3F;
				8'h07: reg_f = v & 8'h3F;
				8'h08: reg_m = v & 8'h0F;
				default: ;
			endcase
		end
	endtask
	task rd(input [7:0] a, input [7:0] exp);
		begin
			REG_ADDR = a;
			REG_RD = 1'b1;
			tick;
			REG_RD = 1'b0;
			tick;
			check(REG_RDATA, exp);
		end
	endtask
	task conv_end;
		begin
			t = 0;
			while (ADC_COMPLETE_EVENT !== 1'b1 && t < 300)
			begin
				tick;
				t = t + 1;
			end
			check({7'h00, ADC_COMPLETE_EVENT}, 8'h01);
			check(ADC_OUTPUT, {adc_val, 1'b0});
			reg_a = reg_a & 6;
			rd(8'h05, reg_a);
		end
	endtask
	task sw_cmp(input [5:0] f, input [3:0] m);
		begin
			check({2'b00, sw[9:4]}, {2'b00, f});
			check({4'h0, sw[3:0]}, {4'h0, m});
		end
	endtask
	task summarize;
		begin
			$display("checks %0d errors %0d", check_count, errors);
			if (errors == 0 && check_count > 0)
				$display("STATUS OK");
			else
				$display("STATUS NOT OK");
			$finish;
		end
	endtask
	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	initial
	begin
		repeat (5) tick;
		RST_B = 1'b1;
		rd(8'h05, 8'h00);
		rd(8'h06, 8'h0E);
		rd(8'h07, 8'h00);
		rd(8'h08, 8'h00);
		rd(8'h09, 8'h00);
		check({5'h00, BIAS_VOLTAGE_SELECT}, 8'h01);
		$display("test reset values done");
		// Every bias, press and release code with random reserved bits
		for (i = 0; i < 8; i = i + 1)
		begin
			d = $random(seed);
			wr(8'h06, {d[7:6], i[2:0], i[2:0]});
			wr(8'h07, d[15:8]);
			wr(8'h08, d[23:16]);
			rd(8'h06, reg_b);
			rd(8'h07, reg_f);
			rd(8'h08, reg_m);
			check({5'h00, BIAS_VOLTAGE_SELECT}, i);
		end
		$display("test field codes done");
		// Automatic states rule until manual mode is on
		for (i = 0; i < 4; i = i + 1)
		begin
			d = $random(seed);
			AUTO_FET_SW = d[5:0];
			AUTO_MATRIX_SW = d[9:6];
			repeat (6) tick;
			sw_cmp(AUTO_FET_SW, AUTO_MATRIX_SW);
		end
		wr(8'h08, 8'h05);
		MANUAL_SW_EN = 1'b1;
		repeat (4) tick;
		sw_cmp(reg_f, reg_m);
		AUTO_FET_SW = ~AUTO_FET_SW;
		wr(8'h07, d[17:10]);
		sw_cmp(reg_f, reg_m);
		MANUAL_SW_EN = 1'b0;
		$display("test switches done");
		// All enable combinations; only trigger with detect plus raw starts one
		for (i = 0; i < 8; i = i + 1)
		begin
			adc_val = $random(seed);
			wr(8'h05, i);
			rd(8'h05, reg_a);
			if (i == 7)
				conv_end;
		end
		// Fast then slow retrigger, completion never serviced
		for (i = 0; i < 2; i = i + 1)
		begin
			adc_lat = i ? 8'h3C : 8'h01;
			adc_val = $random(seed);
			wr(8'h05, 8'h07);
			conv_end;
		end
		check(starts, 3);
		$display("test conversions done");
		wr(8'h05, 8'h06);
		// Key held far shorter than any debounce time, then removal
		KEY_LEVEL = 1'b1;
		repeat (20) tick;
		ACCESSORY_REMOVED = 1'b1;
		repeat (4) tick;
		ACCESSORY_REMOVED = 1'b0;
		repeat (4) tick;
		rd(8'h05, 8'h00);
		check({6'h00, KEY_DETECT_ACTIVE, RAW_MODE_ACTIVE}, 8'h00);
		KEY_LEVEL = 1'b0;
		check(presses, 0);
		// Second reset in mid-run restores defaults
		wr(8'h06, 8'h00);
		RST_B = 1'b0;
		repeat (3) tick;
		RST_B = 1'b1;
		rd(8'h06, 8'h0E);
		$display("test removal and reset done");
		summarize;
	end
endmodule
